//--- dv/spdif_tx_serial_input_port_bench.sv
// Self-checking bench for the serial audio input stage
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module spdif_tx_serial_input_port_bench;
    logic clk_in = 0, nrst_in = 0, ce_in = 0, osr_in = 0, osc = 0, run_osc = 1;
    logic pair_ready_in = 0, hold = 0;
    logic [1:0] fmt_in = 0, wid_in = 0;
    logic [23:0] a, b, l, r, m, ql[$], qr[$];
    wire sclk, fsync, sdata, pair_valid_out, biphase_tick_out, overrun_out;
    wire [23:0] left_out, right_out;
    int n_errors = 0, check_count = 0, ticks, rises, w, dv;
    initial forever #5 clk_in = ~clk_in;
    initial forever #30 if (run_osc) osc = ~osc;
    stx_src src_u (.fmt_in(fmt_in), .wid_in(wid_in), .sclk_out(sclk), .fsync_out(fsync),
        .sdata_out(sdata));
    stx_serin dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .fmt_in(fmt_in),
        .wid_in(wid_in), .osr_in(osr_in), .sclk_in(sclk), .fsync_in(fsync), .sdata_in(sdata),
        .oversample_clock_in(osc), .pair_ready_in(pair_ready_in),
        .pair_valid_out(pair_valid_out), .left_out(left_out), .right_out(right_out),
        .biphase_tick_out(biphase_tick_out), .overrun_out(overrun_out));
    always @(negedge clk_in) pair_ready_in <= hold ? 1'b0 : 1'($urandom);
    always @(posedge osc) rises++;
    always @(posedge clk_in) begin
        if (biphase_tick_out) ticks++;
        if (nrst_in && ce_in && pair_valid_out && pair_ready_in) begin
            `CHK(ql.size() > 0, 1'b1)
            l = ql.pop_front();
            r = qr.pop_front();
            `CHK(left_out, l)
            `CHK(right_out, r)
        end
    end
    task automatic end_sim;
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input logic [1:0] f, input logic [1:0] wd, input int n);
        nrst_in = 0;
        ce_in = 0;
        fmt_in = f;
        wid_in = wd;
        osr_in = wd[0];
        ql.delete();
        qr.delete();
        repeat (6) @(negedge clk_in);
        nrst_in = 1;
        // Held off briefly so the frozen state is seen
        repeat (3) @(negedge clk_in);
        ce_in = 1;
        ticks = 0;
        rises = 0;
        w = (wd == 2'h3) ? 24 : 16 + 2 * wd;
        m = ~((24'h1 << (24 - w)) - 24'h1);
        src_u.lead;
        repeat (n) begin
            a = $urandom;
            b = $urandom;
            // 32 stored, one on the output, one pending; later pairs are dropped
            if (ql.size() < 34) begin
                ql.push_back(a & m);
                qr.push_back(b & m);
            end
            src_u.send(a, b);
        end
        repeat (40) @(negedge clk_in);
        dv = osr_in ? 3 : 2;
        `CHK((rises / dv - ticks) inside {[-2:2]}, 1'b1)
        if (!hold) `CHK(ql.size(), 0)
    endtask
    initial begin
        void'($urandom(32'hb1a41c16));
        for (int f = 0; f < 3; f++) begin
            for (int wd = 0; wd < 4; wd++) begin
                run(2'(f), 2'(wd), 2);
            end
        end
        // Consumer stalled until the FIFO overflows
        hold = 1;
        run(2'h1, 2'h3, 36);
        `CHK(overrun_out, 1'b1)
        run_osc = 0;
        hold = 0;
        repeat (300) @(negedge clk_in);
        `CHK(pair_valid_out, 1'b0)
        `CHK(ql.size(), 0)
        `CHK(overrun_out, 1'b1)
        end_sim;
    end
    initial begin
        // Traffic takes about 400 us
        #600000;
        n_errors++;
        end_sim;
    end
endmodule

//--- dv/stx_serin_chk.sv
// Checker bound to the serial audio input stage
`timescale 1ns/1ps
module stx_serin_chk (
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    input wire [1:0] wid_in,
    input wire oversample_clock_in,
    input wire pair_ready_in,
    input wire pair_valid_out,
    input wire [23:0] left_out,
    input wire [23:0] right_out,
    input wire biphase_tick_out,
    input wire overrun_out
);
    // Bits below the word width must read zero
    wire [23:0] low_m = (wid_in == 2'h3) ? 24'h0 : 24'hff >> (2 * wid_in);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_gap; biphase_tick_out |=> !biphase_tick_out [*7]; endproperty
    a_gap: assert property (p_gap) else $error("tick spacing");
    property p_src; $stable(oversample_clock_in) [*8] |-> !biphase_tick_out; endproperty
    a_src: assert property (p_src) else $error("tick without clock");
    property p_hold;
        pair_valid_out && !pair_ready_in |=> pair_valid_out && $stable({left_out, right_out});
    endproperty
    a_hold: assert property (p_hold) else $error("pair not held");
    property p_sticky; overrun_out |=> overrun_out; endproperty
    a_sticky: assert property (p_sticky) else $error("overrun lost");
    property p_ovr; $rose(overrun_out) |-> $past(pair_valid_out); endproperty
    a_ovr: assert property (p_ovr) else $error("overrun while empty");
    property p_low; pair_valid_out |-> ((left_out | right_out) & low_m) == 24'h0; endproperty
    a_low: assert property (p_low) else $error("low bits set");
    property p_frz;
        !ce_in |=> $stable({pair_valid_out, biphase_tick_out, overrun_out});
    endproperty
    a_frz: assert property (p_frz) else $error("moved while frozen");
    property p_rst; $rose(nrst_in) |-> !pair_valid_out && !overrun_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs after reset");
    c_pop: cover property (pair_valid_out && pair_ready_in);
    c_ovr: cover property ($rose(overrun_out));
    c_tick: cover property (biphase_tick_out);
endmodule
bind stx_serin stx_serin_chk chk_u (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .wid_in(wid_in), .oversample_clock_in(oversample_clock_in), .pair_ready_in(pair_ready_in),
    .pair_valid_out(pair_valid_out), .left_out(left_out), .right_out(right_out),
    .biphase_tick_out(biphase_tick_out), .overrun_out(overrun_out));

//--- dv/stx_src.sv
// Serial audio source model feeding the input stage
`timescale 1ns/1ps
module stx_src (
    input wire [1:0] fmt_in,
    input wire [1:0] wid_in,
    output logic sclk_out = 1'b0,
    output logic fsync_out = 1'b0,
    output logic sdata_out = 1'b0
);
    // One frame of 64 clocks; clock stands low between frames
    task automatic send(input logic [23:0] lw, input logic [23:0] rw);
        int w, d, k;
        w = (wid_in == 2'h3) ? 24 : 16 + 2 * wid_in;
        d = (fmt_in == 2'h1) ? 1 : (fmt_in == 2'h2) ? 32 - w : 0;
        fsync_out = (fmt_in == 2'h1);
        #50;
        for (int p = 0; p < 64; p++) begin
            k = p % 32 - d;
            fsync_out = (p < 32) ^ (fmt_in == 2'h1);
            // Toggles outside the word so a stale bit never matches
            sdata_out = (k >= 0 && k < w) ? (p < 32 ? lw[23 - k] : rw[23 - k]) : ~sdata_out;
            #50 sclk_out = 1'b1;
            #50 sclk_out = 1'b0;
        end
        sdata_out = ~sdata_out;
    endtask
    // Idle-level clock ahead of the first frame so its sync edge is seen
    task automatic lead;
        fsync_out = (fmt_in == 2'h1);
        sdata_out = ~sdata_out;
        #50 sclk_out = 1'b1;
        #50 sclk_out = 1'b0;
    endtask
endmodule

//--- pkg/stx_regs.vh
// Constants for the serial audio input stage
`ifndef STX_REGS_VH
`define STX_REGS_VH
// ****************************************
// Formats
// ****************************************
`define STX_FMT_LJ 2'h0
`define STX_FMT_I2S 2'h1
`define STX_FMT_RJ 2'h2
// ****************************************
// Word widths
// ****************************************
`define STX_WID_16 2'h0
`define STX_WID_18 2'h1
`define STX_WID_20 2'h2
`define STX_WID_24 2'h3
// ****************************************
// Right-justified, I2S and left-justified MSB delays, 64 clocks per frame
// ****************************************
`define STX_RJD_16 6'h10
`define STX_RJD_18 6'h0e
`define STX_RJD_20 6'h0c
`define STX_RJD_24 6'h08
`define STX_I2SD 6'h01
`define STX_LJD 6'h00
// ****************************************
// Oversampling ratios, biphase divide and FIFO depth
// ****************************************
`define STX_OSR_256 1'b0
`define STX_OSR_384 1'b1
`define STX_DIV_256 4'h1
`define STX_DIV_384 4'h2
`define STX_FIFO_DEPTH 32
`endif

//--- rtl/stx_fifo.v
// Sample-pair FIFO with valid and ready on both sides
`timescale 1ns/1ps
module stx_fifo #(
    parameter WIDTH = 48,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output reg out_valid_out,
    input wire out_ready_in,
    output reg [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire wr;
    wire rd;
    assign in_ready_out = (cnt_r != DEPTH[AW:0]);
    assign wr = in_valid_in && in_ready_out;
    // Read data lands in a register; refill when output empty or taken
    assign rd = (cnt_r != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);
    always @(posedge clk_in) begin
        if (ce_in && wr) begin
            mem_r[wp_r] <= in_data_in;
        end
    end
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            out_valid_out <= 1'b0;
            out_data_out <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            if (wr) begin
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
                out_data_out <= mem_r[rp_r];
                out_valid_out <= 1'b1;
            end else if (out_ready_in) begin
                out_valid_out <= 1'b0;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
        end
    end
endmodule

//--- rtl/stx_serin.v
// Serial audio input stage of the biphase transmitter
`timescale 1ns/1ps
`include "stx_regs.vh"
// Function
// - Left-justified: sync high left, low right
// - Sample data and sync on rising clock
// - Left-justified MSB right after sync edge
// - Divide oversampling clock to biphase clock
// - LJ, I2S, RJ formats; 16/18/20/24 bits
// - RJ MSB delay 16/14/12/8 clocks
// - I2S sync low left, high right
module stx_serin #(
    parameter DEPTH = `STX_FIFO_DEPTH,
    parameter AW = 5
) (
    input wire clk_in,
    input wire nrst_in,
    input wire ce_in,
    input wire [1:0] fmt_in,
    input wire [1:0] wid_in,
    input wire osr_in,
    input wire sclk_in,
    input wire fsync_in,
    input wire sdata_in,
    input wire oversample_clock_in,
    input wire pair_ready_in,
    output wire pair_valid_out,
    output wire [23:0] left_out,
    output wire [23:0] right_out,
    output reg biphase_tick_out,
    output reg overrun_out
);
    // ****************************************
    // Synchronisers: serial pins and oversampling clock pass two flops
    // ****************************************
    // Three clocks of latency; serial clock must stay below clk/8
    reg [1:0] sclk_s_r;
    reg [1:0] fs_s_r;
    reg [1:0] sd_s_r;
    reg [1:0] osc_s_r;
    reg sclk_d_r;
    reg osc_d_r;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_s_r <= 2'h0;
            fs_s_r <= 2'h0;
            sd_s_r <= 2'h0;
            osc_s_r <= 2'h0;
            sclk_d_r <= 1'b0;
            osc_d_r <= 1'b0;
        end else if (ce_in) begin
            sclk_s_r <= {sclk_s_r[0], sclk_in};
            fs_s_r <= {fs_s_r[0], fsync_in};
            sd_s_r <= {sd_s_r[0], sdata_in};
            osc_s_r <= {osc_s_r[0], oversample_clock_in};
            sclk_d_r <= sclk_s_r[1];
            osc_d_r <= osc_s_r[1];
        end
    end
    // Rising serial clock edge; sync and data are aligned with it
    wire sclk_rise = sclk_s_r[1] && !sclk_d_r;
    wire osc_rise = osc_s_r[1] && !osc_d_r;
    // ****************************************
    // Biphase clock divider
    // ****************************************
    // 256x frame gives 128x biphase (div 2); 384x gives div 3
    reg [3:0] div_r;
    wire [3:0] div_max = osr_in ? `STX_DIV_384 : `STX_DIV_256;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_r <= 4'h0;
            biphase_tick_out <= 1'b0;
        end else if (ce_in) begin
            biphase_tick_out <= 1'b0;
            if (osc_rise) begin
                if (div_r >= div_max) begin
                    div_r <= 4'h0;
                    biphase_tick_out <= 1'b1;
                end else begin
                    div_r <= div_r + 4'h1;
                end
            end
        end
    end
    // ****************************************
    // Word framing
    // ****************************************
    reg fs_prev_r;
    reg [5:0] bitcnt_r;
    reg [4:0] got_r;
    reg [23:0] shift_r;
    reg [23:0] left_r;
    reg chan_r;
    reg have_left_r;
    reg push_r;
    reg [47:0] pair_r;
    reg [5:0] delay;
    reg [4:0] nbits;
    // ****************************************
    // Width decode
    // ****************************************
    always @* begin
        case (wid_in)
            `STX_WID_16: nbits = 5'h10;
            `STX_WID_18: nbits = 5'h12;
            `STX_WID_20: nbits = 5'h14;
            default: nbits = 5'h18;
        endcase
    end
    // ****************************************
    // Format decode
    // ****************************************
    // Code 3 is unused and falls back to left-justified
    always @* begin
        case (fmt_in)
            `STX_FMT_I2S: delay = `STX_I2SD;
            `STX_FMT_RJ: begin
                case (wid_in)
                    `STX_WID_16: delay = `STX_RJD_16;
                    `STX_WID_18: delay = `STX_RJD_18;
                    `STX_WID_20: delay = `STX_RJD_20;
                    default: delay = `STX_RJD_24;
                endcase
            end
            default: delay = `STX_LJD;
        endcase
    end
    // ****************************************
    // Bit position and capture
    // ****************************************
    wire fs_now = fs_s_r[1];
    wire fs_edge = fs_now != fs_prev_r;
    // Left channel polarity flips in I2S
    wire left_now = (fmt_in == `STX_FMT_I2S) ? !fs_now : fs_now;
    wire [5:0] pos = fs_edge ? 6'h00 : bitcnt_r;
    // Count restarts at the sync edge itself, so a zero delay still lands the MSB
    wire [4:0] got = fs_edge ? 5'h00 : got_r;
    wire take = (pos >= delay) && (got < nbits);
    wire [23:0] shifted = {shift_r[22:0], sd_s_r[1]};
    wire done = take && (got == nbits - 5'h1);
    // Justify the word into the top bits of the 24-bit slot
    wire [23:0] word = shifted << (5'h18 - nbits);
    // Half in progress; a fresh edge overrides the latched channel
    wire cur_left = fs_edge ? left_now : chan_r;
    wire fifo_ready;
    // Positions count from the rise that first shows the new sync level
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fs_prev_r <= 1'b0;
            bitcnt_r <= 6'h00;
            got_r <= 5'h00;
            shift_r <= 24'h000000;
            chan_r <= 1'b0;
        end else if (ce_in && sclk_rise) begin
            fs_prev_r <= fs_now;
            bitcnt_r <= (pos == 6'h3f) ? pos : pos + 6'h01;
            if (fs_edge) begin
                chan_r <= left_now;
            end
            if (take) begin
                shift_r <= shifted;
                got_r <= got + 5'h01;
            end else begin
                got_r <= got;
            end
        end
    end
    // ****************************************
    // Pair assembly
    // ****************************************
    // One pair may wait outside the FIFO; the next one is dropped meanwhile
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            left_r <= 24'h000000;
            have_left_r <= 1'b0;
            push_r <= 1'b0;
            pair_r <= 48'h0;
            overrun_out <= 1'b0;
        end else if (ce_in) begin
            if (push_r && fifo_ready) begin
                push_r <= 1'b0;
            end
            if (sclk_rise && done) begin
                // Pair built when right word completes after a left word
                if (cur_left) begin
                    left_r <= word;
                    have_left_r <= 1'b1;
                end else if (have_left_r) begin
                    have_left_r <= 1'b0;
                    // Sample lost if the previous pair is still waiting
                    if (push_r && !fifo_ready) begin
                        overrun_out <= 1'b1;
                    end else begin
                        pair_r <= {left_r, word};
                        push_r <= 1'b1;
                    end
                end
            end
        end
    end
    // ****************************************
    // Output FIFO
    // ****************************************
    wire [47:0] fifo_q;
    stx_fifo #(
        .WIDTH(48),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .in_valid_in(push_r),
        .in_ready_out(fifo_ready),
        .in_data_in(pair_r),
        .out_valid_out(pair_valid_out),
        .out_ready_in(pair_ready_in),
        .out_data_out(fifo_q)
    );
    assign left_out = fifo_q[47:24];
    assign right_out = fifo_q[23:0];
endmodule
